/* rtl/port_timer.sv */
/*
 * One TDM port: late-cell timer, loss-integration timer, latched flags
 * and the port's configuration word.
 * Assumes tick pulses and cell arrivals from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rto_regs.svh"

module port_timer
   import rto_pkg::*;
(
   input  wire logic        clk_sys_in,
   input  wire logic        rst_in,
   input  wire logic        cell_seen_in,
   input  wire logic        unstructured_transport_in,
   input  wire logic        step_tick_in,
   input  wire logic        ms_tick_in,
   input  wire logic [15:0] loss_integration_period_in,
   input  wire logic        wr_in,
   input  wire logic [15:0] wdata_in,
   output logic      [15:0] word_out,
   output logic             summary_out
);

   port_state_s st_ff;
   port_state_s nxt_st;
   logic [10:0] late_inc;
   logic [15:0] cut_inc;
   logic        late_evt;
   logic        cut_evt;

   // timers, events and register writes
   always_comb
   begin
      nxt_st   = st_ff;
      late_inc = st_ff.late_cnt + 11'h001;
      cut_inc  = st_ff.cut_cnt + 16'h0001;
      late_evt = 1'b0;
      cut_evt  = 1'b0;
      if (cell_seen_in)
      begin
         nxt_st.late_cnt   = 11'h000;
         nxt_st.late_fired = 1'b0;
         nxt_st.cut_cnt    = 16'h0000;
         nxt_st.cut_fired  = 1'b0;
      end
      else
      begin
         if (step_tick_in && !st_ff.late_fired)   // [RL6]
         begin
            nxt_st.late_cnt = late_inc;
            if (late_inc >= st_ff.late_period)
            begin
               nxt_st.late_fired = 1'b1;
               late_evt          = unstructured_transport_in; // [RL6]
            end
         end
         if (ms_tick_in && !st_ff.cut_fired)      // [RL1]
         begin
            nxt_st.cut_cnt = cut_inc;
            if (cut_inc >= loss_integration_period_in)
            begin
               nxt_st.cut_fired = 1'b1;
               cut_evt          = 1'b1;           // [RL1]
            end
         end
      end
      // a written zero clears; a new event in the same cycle wins
      if (wr_in)
      begin
         nxt_st.late_period = wdata_in[`RTO_LATE_PER_MSB:0];
         nxt_st.late_se     = wdata_in[`RTO_LATE_SE_BIT];
         nxt_st.cut_se      = wdata_in[`RTO_CUT_SE_BIT];
         nxt_st.late_flag   = st_ff.late_flag & wdata_in[`RTO_LATE_ST_BIT]; // [RL8]
         nxt_st.cut_flag    = st_ff.cut_flag & wdata_in[`RTO_CUT_ST_BIT];   // [RL8]
      end
      nxt_st.late_flag = nxt_st.late_flag | late_evt; // [RL8]
      nxt_st.cut_flag  = nxt_st.cut_flag | cut_evt;   // [RL2]
      if (rst_in)
      begin
         nxt_st             = '0;
         nxt_st.late_period = `RTO_LATE_PER_RST;
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      st_ff <= nxt_st;
   end

   // readback word, bit 15 reserved
   assign word_out = {1'b0, st_ff.cut_flag, st_ff.cut_se, st_ff.late_flag,
                      st_ff.late_se, st_ff.late_period};
   assign summary_out = (st_ff.late_flag & st_ff.late_se) |
                        (st_ff.cut_flag & st_ff.cut_se);     // [RL7] [RL9]

endmodule

`default_nettype wire

/* rtl/reassembly_timeout_monitor.sv */
/*
 * Reassembly-side timeout monitor: loss period register, two summary
 * words, 28 per-port timeout words and the shared time-base prescalers.
 * Register map, byte addresses, 16-bit words:
 *    3000        loss integration period in ms, read/write
 *    3002        summary bits of ports 0-15, read-only
 *    3004        summary bits of ports 16-27 in bits 11:0, read-only
 *    3200 + 2p   timeout word of port p
 * Port word: 10:0 late period in 125 us steps, 11 late enable,
 * 12 late flag, 13 cut enable, 14 cut flag, 15 reads zero.
 * Assumes the register port and cell arrival strobes are synchronous to
 * clk_sys_in; reads return data one clock after rd_in.
 */
`timescale 1ns/1ps
`default_nettype none
`include "rto_regs.svh"

module reassembly_timeout_monitor
   import rto_pkg::*;
#(
   parameter int MS_CYCLES   = `RTO_MS_CYCLES,
   parameter int STEP_CYCLES = `RTO_STEP_CYCLES
)
(
   input  wire logic                      clk_sys_in,
   input  wire logic                      rst_in,
   input  wire logic [15:0]               addr_in,
   input  wire logic [15:0]               wdata_in,
   input  wire logic                      wr_in,
   input  wire logic                      rd_in,
   output logic      [15:0]               rdata_out,
   input  wire logic [`RTO_NUM_PORTS-1:0] cell_seen_in,
   input  wire logic [`RTO_NUM_PORTS-1:0] unstructured_transport_in,
   output logic                           receive_timeout_service_flag_out
);

   localparam int NP = `RTO_NUM_PORTS;

   // registered state, per-port words, summaries and decoded address
   top_state_s      st_ff;
   top_state_s      nxt_st;
   word_t           port_word [NP];
   logic [NP-1:0]   port_sum;
   logic [NP-1:0]   port_wr;
   logic [31:0]     sum_all;
   logic [15:0]     sum_low;
   logic [15:0]     sum_high;
   reg_sel_e        addr_sel;
   logic [4:0]      addr_port;

   // true when the address falls on a per-port timeout word
   function automatic logic port_hit(input logic [15:0] a);
      logic [15:0] off;
      logic        in_window;
      logic        even;
      logic        known;
      off       = a - `RTO_PORT_BASE_ADDR;
      in_window = (a >= `RTO_PORT_BASE_ADDR) && (off[15:6] == 10'h000);
      even      = !off[0];                 // odd addresses hit nothing
      known     = (off[5:1] < 5'(NP));     // no words past the last port
      return in_window && even && known;
   endfunction

   // port number selected by a per-port address
   function automatic logic [4:0] port_idx(input logic [15:0] a);
      logic [15:0] off;
      off = a - `RTO_PORT_BASE_ADDR;
      return off[5:1];
   endfunction

   // register addressed by a bus cycle; used by write and read paths
   function automatic reg_sel_e reg_sel(input logic [15:0] a);
      reg_sel_e sel;
      if (a == `RTO_PERIOD_ADDR)
      begin
         sel = sel_period;
      end
      else if (a == `RTO_SUM_LOW_ADDR)
      begin
         sel = sel_sum_low;
      end
      else if (a == `RTO_SUM_HIGH_ADDR)
      begin
         sel = sel_sum_high;
      end
      else if (port_hit(a))
      begin
         sel = sel_port;
      end
      else
      begin
         sel = sel_none;
      end
      return sel;
   endfunction

   // address decode shared by the write strobes and the read multiplexer
   assign addr_sel  = reg_sel(addr_in);
   assign addr_port = port_idx(addr_in);

   // per-port timers, one instance per port
   genvar gp;
   generate
      for (gp = 0; gp < NP; gp++)
      begin : g_port
         assign port_wr[gp] = wr_in && (addr_sel == sel_port) &&
                              (addr_port == 5'(gp));         // [RL2]
         port_timer u_port (
            .clk_sys_in                (clk_sys_in),
            .rst_in                    (rst_in),
            .cell_seen_in              (cell_seen_in[gp]),
            .unstructured_transport_in (unstructured_transport_in[gp]),
            .step_tick_in              (st_ff.step_tick),
            .ms_tick_in                (st_ff.ms_tick),
            .loss_integration_period_in(st_ff.period),
            .wr_in                     (port_wr[gp]),
            .wdata_in                  (wdata_in),
            .word_out                  (port_word[gp]),
            .summary_out               (port_sum[gp])
         );
      end
   endgenerate

   // summary bits, one per port; bits past the last port read zero
   genvar gs;
   generate
      for (gs = 0; gs < 32; gs++)
      begin : g_sum
         if (gs < NP)
         begin : g_used
            assign sum_all[gs] = port_sum[gs];  // [RL4] [RL5]
         end
         else
         begin : g_spare
            assign sum_all[gs] = 1'b0;          // [RL5]
         end
      end
   endgenerate

   // the two summary words as software reads them
   assign sum_low  = sum_all[15:0];             // [RL4]
   assign sum_high = {4'h0, sum_all[27:16]};    // [RL5]

   // prescalers, loss period register and read data
   always_comb
   begin
      nxt_st           = st_ff;
      nxt_st.step_tick = 1'b0;
      nxt_st.ms_tick   = 1'b0;
      // 125 us step base; ticks are registered so all ports see one edge
      if (st_ff.step_cnt == 11'(STEP_CYCLES - 1))
      begin
         nxt_st.step_cnt  = 11'h000;
         nxt_st.step_tick = 1'b1;                  // [RL6]
      end
      else
      begin
         nxt_st.step_cnt = st_ff.step_cnt + 11'h001;
      end
      // millisecond base
      if (st_ff.ms_cnt == 14'(MS_CYCLES - 1))
      begin
         nxt_st.ms_cnt  = 14'h0000;
         nxt_st.ms_tick = 1'b1;                    // [RL1]
      end
      else
      begin
         nxt_st.ms_cnt = st_ff.ms_cnt + 14'h0001;
      end
      // loss period register
      if (wr_in && (addr_sel == sel_period))
      begin
         nxt_st.period = wdata_in;                 // [RL1]
      end
      // read data registered; unmapped addresses read zero
      if (rd_in)
      begin
         unique case (addr_sel)
            sel_period:
            begin
               nxt_st.rdata = st_ff.period;
            end
            sel_sum_low:
            begin
               nxt_st.rdata = sum_low;                // [RL4]
            end
            sel_sum_high:
            begin
               nxt_st.rdata = sum_high;               // [RL5]
            end
            sel_port:
            begin
               nxt_st.rdata = port_word[addr_port];   // [RL2]
            end
            sel_none:
            begin
               nxt_st.rdata = 16'h0000;
            end
            default:
            begin
               nxt_st.rdata = 16'h0000;
            end
         endcase
      end
      if (rst_in)
      begin
         nxt_st        = '0;
         nxt_st.period = `RTO_PERIOD_RST;          // [RL3]
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      st_ff <= nxt_st;
   end

   // outputs
   assign rdata_out = st_ff.rdata;
   assign receive_timeout_service_flag_out = |port_sum; // [RL7]

endmodule

`default_nettype wire

/* rtl/rto_pkg.sv */
/*
 * Types shared by the timeout monitor modules.
 * Assumes rto_regs.svh for the numeric constants.
 */
`default_nettype none

package rto_pkg;

   typedef logic [15:0] word_t;

   // register selected by a register-port address
   typedef enum logic [2:0] {
      sel_none     = 3'b000,
      sel_period   = 3'b001,
      sel_sum_low  = 3'b010,
      sel_sum_high = 3'b011,
      sel_port     = 3'b100
   } reg_sel_e;

   // state of one port's timers and flags
   typedef struct packed {
      logic [10:0] late_period;
      logic        late_se;
      logic        late_flag;
      logic        cut_se;
      logic        cut_flag;
      logic [10:0] late_cnt;
      logic        late_fired;
      logic [15:0] cut_cnt;
      logic        cut_fired;
   } port_state_s;

   // state of the shared prescalers and the register port
   typedef struct packed {
      logic [10:0] step_cnt;
      logic [13:0] ms_cnt;
      logic        step_tick;
      logic        ms_tick;
      word_t       period;
      word_t       rdata;
   } top_state_s;

endpackage

`default_nettype wire

/* rtl/rto_regs.svh */
/*
 * Register map, field positions, reset values and timing counts of the
 * reassembly-side timeout monitor.
 * Assumes a 16-bit register port with byte addresses and a 10 MHz clock.
 */
// Summary of operation
// RL1: 16-bit millisecond loss period declares circuit cut
// RL2: cut flag set in port word, 2-byte stride
// RL3: loss period resets to 09c4 (2.5 s)
// RL4: summary low word: bit n is port n
// RL5: summary high word: ports 16-27, bits 15:12 zero
// RL6: late timeout in 125 us steps, unstructured only
// RL7: service enables gate flags into summary and service
// RL8: flags latch; software clears by writing zero
// RL9: summary bit is OR of enabled latched flags
`ifndef RTO_REGS_SVH
`define RTO_REGS_SVH

// register addresses
`define RTO_PERIOD_ADDR    16'h3000
`define RTO_SUM_LOW_ADDR   16'h3002
`define RTO_SUM_HIGH_ADDR  16'h3004
`define RTO_PORT_BASE_ADDR 16'h3200
`define RTO_NUM_PORTS      28
`define RTO_LOW_PORTS      16

// per-port word fields
`define RTO_LATE_PER_MSB   10
`define RTO_LATE_SE_BIT    11
`define RTO_LATE_ST_BIT    12
`define RTO_CUT_SE_BIT     13
`define RTO_CUT_ST_BIT     14

// reset values
`define RTO_PERIOD_RST     16'h09c4
`define RTO_LATE_PER_RST   11'h7ff

// timing
`define RTO_CLK_PERIOD_NS  100
`define RTO_STEP_NS        125000
`define RTO_MS_NS          1000000
`define RTO_STEP_CYCLES    (`RTO_STEP_NS / `RTO_CLK_PERIOD_NS)
`define RTO_MS_CYCLES      (`RTO_MS_NS / `RTO_CLK_PERIOD_NS)

`endif

/* verif/rto_properties.sv */
/*
 * Port-level checker for the reassembly timeout monitor.
 * Assumes binding to reassembly_timeout_monitor, one clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module rto_properties
#(
   parameter int MS_CYCLES = 4
)
(
   input wire logic        clk_sys_in,
   input wire logic        rst_in,
   input wire logic [15:0] addr_in,
   input wire logic [15:0] wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [15:0] rdata_out,
   input wire logic [27:0] cell_seen_in,
   input wire logic [27:0] unstructured_transport_in,
   input wire logic        receive_timeout_service_flag_out
);
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (rst_in);

   // register port and service flag relations
   AST_RST_PERIOD: assert property ($fell(rst_in) && rd_in
      && addr_in == 16'h3000 |=> rdata_out == 16'h09c4)
      else $error("period reset value wrong");
   AST_PERIOD_RW: assert property ((wr_in && addr_in == 16'h3000)
      ##1 !wr_in ##1 (rd_in && !wr_in && addr_in == 16'h3000)
      |=> rdata_out == $past(wdata_in, 3))
      else $error("period readback wrong");
   AST_HIGH_RSVD: assert property (rd_in && addr_in == 16'h3004
      |=> rdata_out[15:12] == 4'h0) else $error("reserved bits set");
   AST_PORT_B15: assert property (rd_in && addr_in[15:8] == 8'h32
      |=> !rdata_out[15]) else $error("port word bit 15 set");
   AST_UNMAPPED: assert property (rd_in && addr_in == 16'h3006
      |=> rdata_out == 16'h0000) else $error("unmapped read not zero");
   AST_RD_HOLD: assert property (!rd_in |=> $stable(rdata_out))
      else $error("read data moved without read");
   AST_SVC_CLR: assert property ($fell(rst_in)
      |-> !receive_timeout_service_flag_out)
      else $error("service flag up after reset");
   AST_SUM_SVC: assert property (rd_in && addr_in == 16'h3002
      ##1 rdata_out != 16'h0000 |-> $past(receive_timeout_service_flag_out))
      else $error("summary set without service flag");
   AST_SVC_HOLD: assert property (receive_timeout_service_flag_out
      && !wr_in |=> receive_timeout_service_flag_out)
      else $error("service flag dropped without write");

   // main scenarios reached
   cover property ($rose(receive_timeout_service_flag_out));
   cover property ($fell(receive_timeout_service_flag_out));
   cover property (rd_in && addr_in == 16'h3004 ##1 rdata_out != 16'h0000);
endmodule

bind reassembly_timeout_monitor rto_properties #(.MS_CYCLES(MS_CYCLES))
   i_rto_properties (
   .clk_sys_in                      (clk_sys_in),
   .rst_in                          (rst_in),
   .addr_in                         (addr_in),
   .wdata_in                        (wdata_in),
   .wr_in                           (wr_in),
   .rd_in                           (rd_in),
   .rdata_out                       (rdata_out),
   .cell_seen_in                    (cell_seen_in),
   .unstructured_transport_in       (unstructured_transport_in),
   .receive_timeout_service_flag_out(receive_timeout_service_flag_out)
);

`default_nettype wire

/* verif/testbench.sv */
/*
 * Self-checking bench for the reassembly timeout monitor.
 * Assumes rto_pkg compiled first; ms prescaler shortened to 4 cycles.
 */
`timescale 1ns/1ps
`default_nettype none

module testbench;
   import rto_pkg::*;
   localparam int MS = 4;
   logic        clk_sys_in;
   logic        rst_in;
   logic        wr_in;
   logic        rd_in;
   word_t       addr_in;
   word_t       wdata_in;
   word_t       rdata_out;
   logic [27:0] cell_seen_in;
   logic [27:0] unst;
   logic        svc;
   int          err_total;
   int          n_checks;

   reassembly_timeout_monitor #(.MS_CYCLES(MS)) i_reassembly_timeout_monitor (
      .clk_sys_in                      (clk_sys_in),
      .rst_in                          (rst_in),
      .addr_in                         (addr_in),
      .wdata_in                        (wdata_in),
      .wr_in                           (wr_in),
      .rd_in                           (rd_in),
      .rdata_out                       (rdata_out),
      .cell_seen_in                    (cell_seen_in),
      .unstructured_transport_in       (unst),
      .receive_timeout_service_flag_out(svc)
   );

   // 10 MHz clock
   initial
   begin
      clk_sys_in = 1'b0;
      forever #50 clk_sys_in = ~clk_sys_in;
   end

   task automatic check(input word_t seen, input word_t exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input word_t a, input word_t d);
      @(posedge clk_sys_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_sys_in);
      wr_in <= 1'b0;
   endtask

   task automatic rd(input word_t a, input word_t e);
      @(posedge clk_sys_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 check(rdata_out, e);
   endtask

   task automatic cells(input logic [27:0] m);
      @(posedge clk_sys_in);
      cell_seen_in <= m;
      @(posedge clk_sys_in);
      cell_seen_in <= '0;
   endtask

   task automatic complete_run;
      $display("checks %0d mismatches %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   // reset values, read in the first cycle after release
   task automatic test_reset;
      rst_in  <= 1'b0;
      addr_in <= 16'h3000;
      rd_in   <= 1'b1;
      @(posedge clk_sys_in);
      rd_in <= 1'b0;
      #1 check(rdata_out, 16'h09c4);
      for (int p = 0; p < 28; p++)
         rd(16'h3200 + 16'(2 * p), 16'h07ff);
      rd(16'h3002, 16'h0000);
      rd(16'h3004, 16'h0000);
      rd(16'h3006, 16'h0000);
      $display("test reset done");
   endtask

   // period read-write, summaries refuse writes
   task automatic test_regs;
      wr(16'h3000, 16'h1234);
      rd(16'h3000, 16'h1234);
      wr(16'h3002, 16'hffff);
      rd(16'h3002, 16'h0000);
      wr(16'h3004, 16'hffff);
      rd(16'h3004, 16'h0000);
      $display("test regs done");
   endtask

   // cut after 9..12 cycles of loss, latch, clear, mask; the cell pulse
   // restarts every loss count before the short period can fire at once
   task automatic test_cut;
      cells('1);
      wr(16'h3000, 16'h0003);
      wr(16'h3200, 16'h2000);
      wr(16'h3222, 16'h2000);
      for (int i = 0; i < 8; i++)
      begin
         cells(28'h0000001);
         repeat (4) @(posedge clk_sys_in);
      end
      rd(16'h3200, 16'h2000);
      repeat (6) @(posedge clk_sys_in);
      rd(16'h3200, 16'h6000);
      rd(16'h3222, 16'h6000);
      rd(16'h3002, 16'h0001);
      rd(16'h3004, 16'h0002);
      check({15'h0, svc}, 16'h0001);
      wr(16'h3222, 16'h2000);
      rd(16'h3222, 16'h2000);
      rd(16'h3004, 16'h0000);
      wr(16'h3200, 16'h4000);
      rd(16'h3200, 16'h4000);
      rd(16'h3002, 16'h0000);
      check({15'h0, svc}, 16'h0000);
      $display("test cut done");
   endtask

   // late flag only in unstructured mode
   task automatic test_late;
      wr(16'h3000, 16'hffff);
      wr(16'h3202, 16'h0801);
      wr(16'h3204, 16'h0801);
      unst <= 28'h0000002;
      cells('1);
      repeat (1300) @(posedge clk_sys_in);
      rd(16'h3202, 16'h1801);
      rd(16'h3204, 16'h0801);
      rd(16'h3002, 16'h0002);
      check({15'h0, svc}, 16'h0001);
      $display("test late done");
   endtask

   // main sequence
   initial
   begin
      rst_in       = 1'b1;
      wr_in        = 1'b0;
      rd_in        = 1'b0;
      addr_in      = '0;
      wdata_in     = '0;
      cell_seen_in = '0;
      unst         = '0;
      err_total    = 0;
      n_checks     = 0;
      repeat (6) @(posedge clk_sys_in);
      test_reset();
      test_regs();
      test_cut();
      test_late();
      complete_run();
   end

   // watchdog
   initial
   begin
      repeat (5000) @(posedge clk_sys_in);
      err_total++;
      $display("unexpected at %0t: timeout", $time);
      complete_run();
   end
endmodule

`default_nettype wire
